/* File: verilog/ifsb_flag_bank.v */
`timescale 1ns/1ps
`include "ifsb_defines.vh"

// Functional notes
// - bit 15 unused, reads zero, ignores writes
// - bit 14 set by dma channel one done
// - bit 4 set by dma channel zero done
// - bit 13 set by adc group done
// - bit 12 set by uart1 transmit request
// - bit 11 set by uart1 receive request
// - bit 10 set by spi1 event request
// - bit 9 set by spi1 fault request
// - bit 8 set by timer3 request
// - bit 7 set by timer2 request
// - bit 6 set by output compare two
// - bit 5 set by input capture two
// - bit 3 set by timer1 request
// - flag reads one after request or software write/set of one, else zero
// - flags read/write, zero after reset
// - bit 2 set by output compare one
// - bit 1 set by input capture one
// - bit 0 set by external irq zero
module ifsb_flag_bank #(
  parameter WIDTH = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire dma_ch1_done,
  input wire adc_group_done,
  input wire uart1_transmit_req,
  input wire uart1_receive_req,
  input wire spi1_event_req,
  input wire spi1_fault_req,
  input wire timer3_req,
  input wire timer2_req,
  input wire out_compare2_req,
  input wire in_capture2_req,
  input wire dma_ch0_done,
  input wire timer1_req,
  input wire out_compare1_req,
  input wire in_capture1_req,
  input wire ext_irq0_req,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [WIDTH-1:0] interrupt_flag_status_0,
  output reg any_pending_q
);

  wire [WIDTH-1:0] src_vec;
  wire [WIDTH-1:0] flag_vec;
  reg [4:0] awaddr_q;
  reg aw_held_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_held_q;
  wire do_write;
  reg [WIDTH-1:0] wr_en_v;
  reg [WIDTH-1:0] set_en_v;
  reg [WIDTH-1:0] clr_en_v;
  wire [WIDTH-1:0] lane_mask;
  reg [31:0] rdata_d;
  reg [1:0] rresp_d;
  reg wr_ok;

  // channel handshake strobes
  wire aw_take;
  wire w_take;
  wire ar_take;

  // next values of the registers below
  reg aw_held_d;
  reg w_held_d;
  reg [4:0] awaddr_d;
  reg [31:0] wdata_d;
  reg [3:0] wstrb_d;
  reg bvalid_d;
  reg [1:0] bresp_d;
  reg rvalid_d;
  reg [WIDTH-1:0] status_d;
  reg pending_d;

  // source requests placed on their flag positions
  assign src_vec[15] = 1'b0;
  assign src_vec[`IFSB_POS_DMA_CH1] = dma_ch1_done;
  assign src_vec[`IFSB_POS_ADC_GROUP] = adc_group_done;
  assign src_vec[`IFSB_POS_UART1_TRANSMIT] = uart1_transmit_req;
  assign src_vec[`IFSB_POS_UART1_RECEIVE] = uart1_receive_req;
  assign src_vec[`IFSB_POS_SPI1_EVENT] = spi1_event_req;
  assign src_vec[`IFSB_POS_SPI1_FAULT] = spi1_fault_req;
  assign src_vec[`IFSB_POS_TIMER3] = timer3_req;
  assign src_vec[`IFSB_POS_TIMER2] = timer2_req;
  assign src_vec[`IFSB_POS_OUT_COMPARE2] = out_compare2_req;
  assign src_vec[`IFSB_POS_IN_CAPTURE2] = in_capture2_req;
  assign src_vec[`IFSB_POS_DMA_CH0] = dma_ch0_done;
  assign src_vec[`IFSB_POS_TIMER1] = timer1_req;
  assign src_vec[`IFSB_POS_OUT_COMPARE1] = out_compare1_req;
  assign src_vec[`IFSB_POS_IN_CAPTURE1] = in_capture1_req;
  assign src_vec[`IFSB_POS_EXT_IRQ0] = ext_irq0_req;

  // address and data channels held until both present
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign do_write = aw_held_q && w_held_q;

  // a channel moves one item when valid and ready meet
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // next write capture; a finished write frees both slots
  always @* begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_d = 1'b1;
        awaddr_d = s_axi_awaddr;
      end
      if (w_take) begin
        w_held_d = 1'b1;
        wdata_d = s_axi_wdata;
        wstrb_d = s_axi_wstrb;
      end
    end
  end

  // write capture registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
    end
  end

  // byte lanes cover the low sixteen bits only
  assign lane_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // decode write into direct, set and clear strobes
  always @* begin
    wr_en_v = {WIDTH{1'b0}};
    set_en_v = {WIDTH{1'b0}};
    clr_en_v = {WIDTH{1'b0}};
    wr_ok = 1'b1;
    if (do_write) begin
      case (awaddr_q)
        `IFSB_FLAG_STATUS_OFFSET: begin
          wr_en_v = lane_mask & `IFSB_IMPL_MASK;
        end
        `IFSB_SET_OFFSET: begin
          set_en_v = lane_mask & wdata_q[15:0] & `IFSB_IMPL_MASK;
        end
        `IFSB_CLEAR_OFFSET: begin
          clr_en_v = lane_mask & wdata_q[15:0] & `IFSB_IMPL_MASK;
        end
        `IFSB_PENDING_OFFSET: begin
          wr_ok = 1'b1; // read-only, write dropped
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
    end
  end

  // next write response; it stands until bready takes it
  always @* begin
    bvalid_d = s_axi_bvalid;
    bresp_d = s_axi_bresp;
    if (do_write) begin
      bvalid_d = 1'b1;
      bresp_d = wr_ok ? `IFSB_RESP_OKAY : `IFSB_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // write response registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IFSB_RESP_OKAY;
    end else begin
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
    end
  end

  // one sticky cell per implemented flag
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH - 1; gi = gi + 1) begin : g_flag
      ifsb_flag_cell u_cell (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_set(src_vec[gi]),
        .wr_en(wr_en_v[gi]),
        .wr_val(wdata_q[gi]),
        .set_en(set_en_v[gi]),
        .clr_en(clr_en_v[gi]),
        .flag_q(flag_vec[gi])
      );
    end
  endgenerate
  assign flag_vec[WIDTH-1] = 1'b0;

  // next processor-side copy; top bit never shows a flag
  always @* begin
    status_d = flag_vec & `IFSB_IMPL_MASK;
    pending_d = |flag_vec;
  end

  // registered copy of the flags for the processor side
  always @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_flag_status_0 <= `IFSB_FLAG_RESET;
      any_pending_q <= 1'b0;
    end else begin
      interrupt_flag_status_0 <= status_d;
      any_pending_q <= pending_d;
    end
  end

  // read data mux
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rdata_d = 32'h0000_0000;
    rresp_d = `IFSB_RESP_OKAY;
    case (s_axi_araddr)
      `IFSB_FLAG_STATUS_OFFSET: begin
        rdata_d = {16'h0000, flag_vec & `IFSB_IMPL_MASK};
      end
      `IFSB_SET_OFFSET: begin
        rdata_d = 32'h0000_0000;
      end
      `IFSB_CLEAR_OFFSET: begin
        rdata_d = 32'h0000_0000;
      end
      `IFSB_PENDING_OFFSET: begin
        rdata_d = {31'h0000_0000, |flag_vec};
      end
      default: begin
        rresp_d = `IFSB_RESP_SLVERR;
      end
    endcase
  end

  // next read valid; data stands until rready takes it
  always @* begin
    rvalid_d = s_axi_rvalid;
    if (ar_take) begin
      rvalid_d = 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // read response registers, data captured with the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IFSB_RESP_OKAY;
    end else begin
      s_axi_rvalid <= rvalid_d;
      if (ar_take) begin
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rresp_d;
      end
    end
  end

endmodule

/* File: common/ifsb_defines.vh */
`ifndef IFSB_DEFINES_VH
`define IFSB_DEFINES_VH

// register byte offsets
`define IFSB_FLAG_STATUS_OFFSET 5'h00
`define IFSB_SET_OFFSET 5'h04
`define IFSB_CLEAR_OFFSET 5'h08
`define IFSB_PENDING_OFFSET 5'h0C

// flag positions
`define IFSB_POS_EXT_IRQ0 0
`define IFSB_POS_IN_CAPTURE1 1
`define IFSB_POS_OUT_COMPARE1 2
`define IFSB_POS_TIMER1 3
`define IFSB_POS_DMA_CH0 4
`define IFSB_POS_IN_CAPTURE2 5
`define IFSB_POS_OUT_COMPARE2 6
`define IFSB_POS_TIMER2 7
`define IFSB_POS_TIMER3 8
`define IFSB_POS_SPI1_FAULT 9
`define IFSB_POS_SPI1_EVENT 10
`define IFSB_POS_UART1_RECEIVE 11
`define IFSB_POS_UART1_TRANSMIT 12
`define IFSB_POS_ADC_GROUP 13
`define IFSB_POS_DMA_CH1 14

// implemented bits and reset value
`define IFSB_IMPL_MASK 16'h7FFF
`define IFSB_FLAG_RESET 16'h0000

// axi responses
`define IFSB_RESP_OKAY 2'h0
`define IFSB_RESP_SLVERR 2'h2

`endif

/* File: verilog/ifsb_flag_cell.v */
`timescale 1ns/1ps
`include "ifsb_defines.vh"

// one sticky flag: source set wins over software write
module ifsb_flag_cell (
  input wire aclk,
  input wire aresetn,
  input wire src_set,
  input wire wr_en,
  input wire wr_val,
  input wire set_en,
  input wire clr_en,
  output reg flag_q
);

  reg flag_d;

  // next value: hardware set has top priority
  always @* begin
    flag_d = flag_q;
    if (wr_en) begin
      flag_d = wr_val;
    end
    if (set_en) begin
      flag_d = 1'b1;
    end
    if (clr_en) begin
      flag_d = 1'b0;
    end
    if (src_set) begin
      flag_d = 1'b1;
    end
  end

  // flag storage
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule

/* File: tb/ifsb_sources.sv */
`timescale 1ns/1ps
// peripheral request sources, one line per flag position
module ifsb_sources (
  input wire [14:0] fire,
  output wire dma_ch1_done,
  output wire adc_group_done,
  output wire uart1_transmit_req,
  output wire uart1_receive_req,
  output wire spi1_event_req,
  output wire spi1_fault_req,
  output wire timer3_req,
  output wire timer2_req,
  output wire out_compare2_req,
  output wire in_capture2_req,
  output wire dma_ch0_done,
  output wire timer1_req,
  output wire out_compare1_req,
  output wire in_capture1_req,
  output wire ext_irq0_req
);
  // request lines follow fire bit for bit, msb first
  assign {dma_ch1_done, adc_group_done, uart1_transmit_req,
    uart1_receive_req, spi1_event_req, spi1_fault_req, timer3_req,
    timer2_req, out_compare2_req, in_capture2_req, dma_ch0_done,
    timer1_req, out_compare1_req, in_capture1_req, ext_irq0_req} = fire;
endmodule

/* File: tb/ifsb_flag_bank_assertions.sv */
`timescale 1ns/1ps
// flag and bus timing checks at the bank ports
module ifsb_flag_bank_assertions #(
  parameter WIDTH = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire dma_ch1_done,
  input wire dma_ch0_done,
  input wire timer1_req,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [WIDTH-1:0] interrupt_flag_status_0,
  input wire any_pending_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write channels taken in one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_top_bit_zero: assert property (!interrupt_flag_status_0[15])
    else $error("top flag bit set");
  a_dma1_sets: assert property (dma_ch1_done |-> ##2
    interrupt_flag_status_0[14]) else $error("dma1 flag lost");
  a_dma0_sets: assert property (dma_ch0_done |-> ##2
    interrupt_flag_status_0[4]) else $error("dma0 flag lost");
  a_timer1_sets: assert property (timer1_req |-> ##2
    interrupt_flag_status_0[3]) else $error("timer1 flag lost");
  a_pend_or: assert property (any_pending_q == |interrupt_flag_status_0)
    else $error("pending summary wrong");
  a_reset_clear: assert property ($rose(aresetn) |->
    interrupt_flag_status_0 == 16'h0000) else $error("flags not cleared");
  a_wr_answer: assert property (s_wr_take |-> ##[1:4] s_axi_bvalid)
    else $error("no write response");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("no read response");
endmodule
bind ifsb_flag_bank ifsb_flag_bank_assertions #(.WIDTH(WIDTH)) chk_i (.*);

/* File: tb/interrupt_flag_status_bank0_bench.sv */
`timescale 1ns/1ps
`include "ifsb_defines.vh"
module interrupt_flag_status_bank0_bench;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, v, m, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [14:0] fire = 0, model;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, any_pending_q;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] interrupt_flag_status_0;
  wire dma_ch1_done, adc_group_done, uart1_transmit_req, uart1_receive_req,
    spi1_event_req, spi1_fault_req, timer3_req, timer2_req,
    out_compare2_req, in_capture2_req, dma_ch0_done, timer1_req,
    out_compare1_req, in_capture1_req, ext_irq0_req;
  int err_total = 0, total_checks = 0;
  ifsb_flag_bank dut (.*);
  ifsb_sources src (.*);
  always #4 aclk = ~aclk;
  // expected read word for a flag image
  function [31:0] exp_rd(input [14:0] f);
    return {17'h00000, f};
  endfunction
  // flag bits that the byte strobes reach
  function [14:0] lanes(input [3:0] s);
    return {{7{s[1]}}, {8{s[0]}}};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one write, address and data offered together
  task wr(input [4:0] a, input [15:0] dd);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, dd};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ad |= s_axi_awvalid && s_axi_awready;
      wd |= s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ad) s_axi_awvalid <= 0;
      if (wd) s_axi_wvalid <= 0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 0;
  endtask
  task rd(input [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 0;
    do @(negedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 0;
  endtask
  // one-cycle request pulse on chosen sources
  task pulse(input [14:0] f);
    @(posedge aclk);
    fire <= f;
    @(posedge aclk);
    fire <= 0;
    model |= f;
  endtask
  // watchdog against a hung handshake
  initial begin
    #200000;
    err_total++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'hDE138707));
    model = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd(`IFSB_FLAG_STATUS_OFFSET);
    chk(v, 0);
    wr(`IFSB_FLAG_STATUS_OFFSET, 16'hFFFF);
    rd(`IFSB_FLAG_STATUS_OFFSET);
    chk(v, 32'h00007FFF);
    // each source alone, after a clear of all flags
    for (int b = 0; b < 15; b++) begin
      wr(`IFSB_CLEAR_OFFSET, 16'hFFFF);
      model = 0;
      pulse(15'h0001 << b);
      rd(`IFSB_FLAG_STATUS_OFFSET);
      chk(v, exp_rd(model));
    end
    // source fires on the very edge that writes zero
    fork
      wr(`IFSB_FLAG_STATUS_OFFSET, 16'h0000);
      begin
        repeat (2) @(posedge aclk);
        fire <= 15'h0008;
        @(posedge aclk);
        fire <= 0;
      end
    join
    rd(`IFSB_FLAG_STATUS_OFFSET);
    chk(v, 32'h00000008);
    model = 15'h0008;
    wr(5'h10, 16'h0001);
    chk(r, `IFSB_RESP_SLVERR);
    wr(`IFSB_PENDING_OFFSET, 16'h0001);
    chk(r, `IFSB_RESP_OKAY);
    rd(`IFSB_SET_OFFSET);
    chk(v, 0);
    rd(5'h14);
    chk(r, `IFSB_RESP_SLVERR);
    // random writes, sets, clears and pulses
    for (int k = 0; k < 40; k++) begin
      d = $urandom;
      m = $urandom;
      s_axi_wstrb <= d[19:16];
      wr(`IFSB_FLAG_STATUS_OFFSET, d[15:0]);
      model = (model & ~lanes(d[19:16])) | (d[14:0] & lanes(d[19:16]));
      pulse(m[14:0]);
      wr(k[0] ? `IFSB_CLEAR_OFFSET : `IFSB_SET_OFFSET, m[31:16]);
      model = k[0] ? model & ~(m[30:16] & lanes(d[19:16]))
        : model | (m[30:16] & lanes(d[19:16]));
      rd(`IFSB_FLAG_STATUS_OFFSET);
      chk(v, exp_rd(model));
      @(negedge aclk);
      chk(interrupt_flag_status_0, exp_rd(model));
      chk(any_pending_q, |model);
      rd(`IFSB_PENDING_OFFSET);
      chk(v, {31'h0, |model});
    end
    wrap_up;
  end
endmodule
